/* design/adc_acquisition_timer.sv */
// Acquisition timer: count registers, AHB-Lite slave and sampling-phase counter.
// Assumes hclk at 40 MHz feeds a divider that makes the converter clock tick,
// and that the sequencer downstream reacts to conv_start.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module adc_acquisition_timer
   import acq_timer_pkg::*;
(
   input  wire logic        hclk,       // Bus clock
   input  wire logic        hresetn,    // Async reset, active low
   input  wire logic        hsel,       // Slave select
   input  wire logic [31:0] haddr,      // Byte address
   input  wire logic [1:0]  htrans,     // Transfer type
   input  wire logic        hwrite,     // Write when high
   input  wire logic [2:0]  hsize,      // Transfer size, word only
   input  wire logic [31:0] hwdata,     // Write data
   input  wire logic        hready,     // Bus ready in
   output logic      [31:0] hrdata,     // Read data
   output logic             hreadyout,  // Slave ready
   output logic             hresp,      // Always OKAY
   output logic             acq_active, // Sampling phase in progress
   output logic             conv_start, // One-cycle conversion start
   output logic             adc_tick    // Converter clock tick
);

   typedef struct packed {
      logic [LOW_W-1:0]  acq_low;
      logic [HIGH_W-1:0] acq_high;
      logic [PRE_W-1:0]  pre;
      logic [DIV_W-1:0]  div;
      logic [DIV_W-1:0]  dcnt;
      logic [CNT_W-1:0]  cnt;
      acq_state_t        st;
      logic              conv;
      logic              dp_wr;
      logic              dp_rd;
      logic              rd_wait;
      logic [4:0]        dp_addr;
      logic [31:0]       rdata;
   } state_t;

   state_t                 r;
   state_t                 n;
   logic                   accept;
   logic                   tick;
   logic                   start_req;
   logic [COUNT_W-1:0]     count;
   logic [31:0]            rd_mux;

   assign accept     = hsel && hready && htrans[1];
   assign tick       = (r.dcnt >= r.div);
   assign count      = {r.acq_high, r.acq_low};
   assign start_req  = r.dp_wr && (r.dp_addr == ADDR_CTRL) && hwdata[CTRL_START];

   assign hrdata     = r.rdata;
   assign hreadyout  = !(r.dp_rd && !r.rd_wait);
   assign hresp      = 1'b0;
   assign acq_active = (r.st == ST_ACQ);
   assign conv_start = r.conv;
   assign adc_tick   = tick;

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (r.dp_addr)
         ADDR_LOW:
            rd_mux[LOW_W-1:0] = r.acq_low;
         // R3 upper bits zero
         ADDR_HIGH:
            rd_mux[HIGH_W-1:0] = r.acq_high;
         ADDR_PRE:
            rd_mux[PRE_W-1:0] = r.pre;
         ADDR_CTRL:
            rd_mux[CTRL_DIV_LSB +: DIV_W] = r.div;
         ADDR_STATUS: begin
            rd_mux[STAT_ACQ] = (r.st == ST_ACQ);
            rd_mux[STAT_CNT_LSB +: CNT_W] = r.cnt;
         end
         default:
            rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      n      = r;
      n.conv = 1'b0;

      // Converter clock divider, free running
      if (tick) begin
         n.dcnt = '0;
      end else begin
         n.dcnt = r.dcnt + 4'h1;
      end

      // Write data phase commits at its end
      if (r.dp_wr) begin
         n.dp_wr = 1'b0;
         unique case (r.dp_addr)
            // R1 low count byte
            ADDR_LOW:
               n.acq_low = hwdata[LOW_W-1:0];
            // R2 high count bits
            ADDR_HIGH:
               n.acq_high = hwdata[HIGH_W-1:0];
            ADDR_PRE:
               n.pre = hwdata[PRE_W-1:0];
            ADDR_CTRL:
               n.div = hwdata[CTRL_DIV_LSB +: DIV_W];
            default: begin
            end
         endcase
      end

      // Read takes one wait state so the data leaves a flip-flop
      if (r.dp_rd) begin
         if (!r.rd_wait) begin
            n.rd_wait = 1'b1;
            n.rdata   = rd_mux;
         end else begin
            n.rd_wait = 1'b0;
            n.dp_rd   = 1'b0;
         end
      end

      if (accept) begin
         n.dp_wr   = hwrite;
         n.dp_rd   = !hwrite;
         n.dp_addr = haddr[4:0];
      end

      unique case (r.st)
         ST_IDLE: begin
            if (start_req) begin
               if (count == 13'h0000) begin
                  if (r.pre == 8'h00) begin
                     // R5 skip acquisition
                     n.conv = 1'b1;
                  end else begin
                     // R6 full length
                     n.cnt = ZERO_LEN;
                     n.st  = ST_ACQ;
                  end
               end else begin
                  // R8 load down-counter
                  n.cnt = {1'b0, count};
                  n.st  = ST_ACQ;
               end
            end
         end
         ST_ACQ: begin
            // R4 one step per tick
            if (tick) begin
               if (r.cnt == CNT_LAST) begin
                  // R8 expiry starts conversion
                  n.cnt  = '0;
                  n.st   = ST_IDLE;
                  n.conv = 1'b1;
               end else begin
                  n.cnt = r.cnt - CNT_LAST;
               end
            end
         end
      endcase
   end

   // R7 clear on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r          <= '0;
         r.acq_low  <= LOW_RST;
         r.acq_high <= HIGH_RST;
         r.pre      <= PRE_RST;
         r.div      <= DIV_RST;
         r.st       <= ST_IDLE;
      end else begin
         r <= n;
      end
   end

   // Helper logic for checking the phase length
   logic [CNT_W-1:0] h_ticks;
   logic [CNT_W-1:0] h_len;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         h_ticks <= '0;
         h_len   <= '0;
      end else if (r.st == ST_IDLE && n.st == ST_ACQ) begin
         h_ticks <= '0;
         h_len   <= n.cnt;
      end else if (r.st == ST_ACQ && tick) begin
         h_ticks <= h_ticks + CNT_LAST;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic wr_low;
   logic wr_high;
   logic rd_high;
   logic rd_low;
   logic rd_ctrl;

   assign wr_low  = r.dp_wr && (r.dp_addr == ADDR_LOW);
   assign wr_high = r.dp_wr && (r.dp_addr == ADDR_HIGH);
   assign rd_high = r.dp_rd && !r.rd_wait && (r.dp_addr == ADDR_HIGH);
   assign rd_low  = r.dp_rd && !r.rd_wait && (r.dp_addr == ADDR_LOW);
   assign rd_ctrl = r.dp_rd && !r.rd_wait && (r.dp_addr == ADDR_CTRL);

   sequence s_start_zero_nopre;
      start_req && r.st == ST_IDLE && count == 13'h0000 && r.pre == 8'h00;
   endsequence

   sequence s_start_zero_pre;
      start_req && r.st == ST_IDLE && count == 13'h0000 && r.pre != 8'h00;
   endsequence

   sequence s_start_count;
      start_req && r.st == ST_IDLE && count != 13'h0000;
   endsequence

   sequence s_expire;
      r.st == ST_ACQ && tick && r.cnt == CNT_LAST;
   endsequence

   property p_low_rw;
      wr_low |=> r.acq_low == $past(hwdata[7:0]);
   endproperty
   a_low_rw: assert property (p_low_rw) else $error("low count not stored"); // R1

   property p_low_rd;
      rd_low |=> hrdata == {24'h00_0000, $past(r.acq_low)};
   endproperty
   a_low_rd: assert property (p_low_rd) else $error("low count read wrong"); // R1

   property p_rd_wait;
      r.dp_rd && !r.rd_wait |-> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

   property p_ctrl_rd;
      rd_ctrl |=> hrdata[CTRL_DIV_LSB-1:0] == 8'h00;
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("start bit reads nonzero");

   property p_high_rw;
      wr_high |=> r.acq_high == $past(hwdata[4:0]);
   endproperty
   a_high_rw: assert property (p_high_rw) else $error("high count not stored"); // R2

   property p_high_rsvd;
      rd_high |=> hrdata[31:5] == 27'h0 && hrdata[4:0] == $past(r.acq_high) && hreadyout;
   endproperty
   a_high_rsvd: assert property (p_high_rsvd) else $error("high reserved bits nonzero"); // R3

   property p_len;
      $fell(acq_active) |-> h_ticks == h_len && conv_start;
   endproperty
   a_len: assert property (p_len) else $error("acquisition length wrong"); // R4

   property p_load;
      s_start_count |=> acq_active && r.cnt == {1'b0, $past(count)};
   endproperty
   a_load: assert property (p_load) else $error("count not loaded"); // R8

   property p_skip;
      s_start_zero_nopre |=> !acq_active && conv_start ##1 !conv_start;
   endproperty
   a_skip: assert property (p_skip) else $error("zero count did not skip"); // R5

   property p_full;
      s_start_zero_pre |=> acq_active && r.cnt == ZERO_LEN && !conv_start;
   endproperty
   a_full: assert property (p_full) else $error("zero count not 8192"); // R6

   property p_reset;
      $rose(hresetn) |-> r.acq_low == 8'h00 && r.acq_high == 5'h00 && !acq_active;
   endproperty
   a_reset: assert property (p_reset) else $error("count not cleared at reset"); // R7

   property p_expire;
      s_expire |=> !acq_active && conv_start ##1 !conv_start;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry did not start conversion"); // R8

   property p_hold;
      acq_active && !tick |=> acq_active && r.cnt == $past(r.cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without tick"); // R8

   property p_no_conv_mid;
      acq_active && !(tick && r.cnt == CNT_LAST) |=> !conv_start;
   endproperty
   a_no_conv_mid: assert property (p_no_conv_mid) else $error("early conversion start"); // R4

   property p_cnt_nonzero;
      acq_active |-> r.cnt != '0;
   endproperty
   a_cnt_nonzero: assert property (p_cnt_nonzero) else $error("counter empty while sampling"); // R8

   property p_tick_div;
      tick && r.div != 4'h0 && !(r.dp_wr && r.dp_addr == ADDR_CTRL) |=> !tick;
   endproperty
   a_tick_div: assert property (p_tick_div) else $error("converter tick too frequent"); // R4

endmodule

/* design/acq_timer_pkg.sv */
// Register map, field layout, reset values and state codes of the acquisition timer.
// Assumes a single AHB-Lite slave on hclk with whole-word transfers only.
// Overview of operation
// R1 - Low register holds count bits 7:0
// R2 - High register holds count bits 12:8
// R3 - High register bits 7:5 read zero
// R4 - Nonzero count N gives N converter clocks
// R5 - Zero count, zero precharge skips acquisition
// R6 - Zero count, nonzero precharge gives 8192 clocks
// R7 - All count bits clear on any reset
// R8 - Down-counter loads at start, expiry starts conversion
package acq_timer_pkg;

   localparam logic [4:0]  ADDR_LOW       = 5'h00;
   localparam logic [4:0]  ADDR_HIGH      = 5'h04;
   localparam logic [4:0]  ADDR_PRE       = 5'h08;
   localparam logic [4:0]  ADDR_CTRL      = 5'h0c;
   localparam logic [4:0]  ADDR_STATUS    = 5'h10;

   localparam int          LOW_W          = 8;
   localparam int          HIGH_W         = 5;
   localparam int          COUNT_W        = 13;
   localparam int          CNT_W          = 14;
   localparam int          PRE_W          = 8;
   localparam int          DIV_W          = 4;

   localparam int          CTRL_START     = 0;
   localparam int          CTRL_DIV_LSB   = 8;
   localparam int          STAT_ACQ       = 0;
   localparam int          STAT_CNT_LSB   = 16;

   localparam logic [LOW_W-1:0]  LOW_RST  = 8'h00;
   localparam logic [HIGH_W-1:0] HIGH_RST = 5'h00;
   localparam logic [PRE_W-1:0]  PRE_RST  = 8'h00;
   localparam logic [DIV_W-1:0]  DIV_RST  = 4'h0;

   localparam logic [CNT_W-1:0]  ZERO_LEN = 14'h2000;
   localparam logic [CNT_W-1:0]  CNT_LAST = 14'h0001;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACQ  = 1'b1
   } acq_state_t;

endpackage

/* tb/adc_acquisition_timer_tb.sv */
// Self-checking bench for the acquisition timer: count registers and phase length.
// Assumes the design is the only AHB-Lite slave, so hready is fed from hreadyout.
`timescale 1ns/1ps
module adc_acquisition_timer_tb;
   import acq_timer_pkg::*;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire logic   hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        acq_active;
   logic        conv_start;
   logic        adc_tick;
   logic [31:0] mismatches;
   logic [31:0] checks;
   logic [31:0] rd;
   int          k;

   // Counts, precharge, divider and expected ticks of each acquisition case
   logic [12:0] t_n [6] = '{13'h0001, 13'h0002, 13'h0003, 13'h1fff, 13'h0000, 13'h0000};
   logic [7:0]  t_p [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
   logic [3:0]  t_d [6] = '{4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};
   logic [31:0] t_e [6] = '{32'h1, 32'h2, 32'h3, 32'h1fff, 32'h0, 32'h2000};

   assign hready = hreadyout;

   adc_acquisition_timer adc_acquisition_timer_inst (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hwdata     (hwdata),
      .hready     (hready),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .acq_active (acq_active),
      .conv_start (conv_start),
      .adc_tick   (adc_tick)
   );

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks != 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_ready();
      do @(posedge hclk); while (hready !== 1'b1);
   endtask

   // One single word transfer; read data lands in rd
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {27'h0, a};
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask

   // Loads the count, starts, and counts converter ticks while sampling
   task automatic run_acq(input logic [12:0] n, input logic [7:0] pre,
                          input logic [3:0] div, input logic [31:0] exp);
      logic [31:0] ticks;
      logic        seen_conv;
      ticks = 32'h0;
      seen_conv = 1'b0;
      bus(ADDR_LOW, 1'b1, {24'h0, n[7:0]});
      bus(ADDR_HIGH, 1'b1, {27'h0, n[12:8]});
      bus(ADDR_PRE, 1'b1, {24'h0, pre});
      bus(ADDR_CTRL, 1'b1, {20'h0, div, 8'h01});
      for (int i = 0; i < 9000 && !seen_conv; i++) begin
         @(posedge hclk);
         if (acq_active === 1'b1 && adc_tick === 1'b1) ticks = ticks + 1;
         seen_conv = (conv_start === 1'b1);
      end
      check({31'h0, seen_conv}, 32'h1);
      check(ticks, exp);
      @(posedge hclk);
      check({31'h0, conv_start}, 32'h0);
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      mismatches = 32'h0;
      checks = 32'h0;
      rd = 32'h0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      bus(ADDR_LOW, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(ADDR_HIGH, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(ADDR_LOW, 1'b1, 32'hffff_ffa5);
      bus(ADDR_LOW, 1'b0, 32'h0);
      check(rd, 32'h0000_00a5);
      bus(ADDR_HIGH, 1'b1, 32'hffff_ffff);
      bus(ADDR_HIGH, 1'b0, 32'h0);
      check(rd, 32'h0000_001f);
      bus(ADDR_HIGH, 1'b1, 32'h0000_00ea);
      bus(ADDR_HIGH, 1'b0, 32'h0);
      check(rd, 32'h0000_000a);
      bus(5'h14, 1'b0, 32'h0);
      check(rd, 32'h0);
      for (k = 0; k < 6; k++) begin
         run_acq(t_n[k], t_p[k], t_d[k], t_e[k]);
      end
      bus(ADDR_PRE, 1'b0, 32'h0);
      check(rd, 32'h0000_0005);
      check({31'h0, hresp}, 32'h0);
      // Reset in the middle of a long acquisition
      bus(ADDR_LOW, 1'b1, 32'h0000_0064);
      bus(ADDR_HIGH, 1'b1, 32'h0000_0013);
      bus(ADDR_CTRL, 1'b1, 32'h0000_0001);
      repeat (5) @(posedge hclk);
      // Status sampled seven ticks into a count of 0x1364
      bus(ADDR_STATUS, 1'b0, 32'h0);
      check(rd, 32'h135d_0001);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({31'h0, acq_active}, 32'h0);
      bus(ADDR_LOW, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(ADDR_HIGH, 1'b0, 32'h0);
      check(rd, 32'h0);
      final_report();
   end

   // Cuts a hang short at about two and a half times the expected run
   initial begin
      #1000000;
      mismatches = mismatches + 1;
      final_report();
   end

endmodule
